// File: design/dswd_pkg.sv
// Package with constants and types for the dual-stage watchdog
package dswd_pkg;
  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int unsigned TIMEOUT_WIDTH = 32;
  localparam int unsigned SYNC_DEPTH = 2;

  // ------------------------------------------------------------
  // Stage actions
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    DSWD_ACT_NONE = 3'h0,
    DSWD_ACT_RESET = 3'h1,
    DSWD_ACT_NMI = 3'h2,
    DSWD_ACT_SMI = 3'h3,
    DSWD_ACT_SCI = 3'h4,
    DSWD_ACT_DELAY = 3'h5
  } dswd_action_type;

  // One stage setting: time-out in clock cycles and action
  typedef struct packed {
    logic [TIMEOUT_WIDTH-1:0] timeout;
    dswd_action_type action;
  } dswd_stage_cfg_type;

  // Event pulses toward the processor and module
  typedef struct packed {
    logic module_reset;
    logic nmi;
    logic system_management_irq;
    logic os_control_irq;
  } dswd_event_type;

  // ------------------------------------------------------------
  // Reset values, count step and edge pattern
  // ------------------------------------------------------------
  localparam logic [TIMEOUT_WIDTH-1:0] COUNT_ZERO = 32'h0000_0000;
  localparam logic [TIMEOUT_WIDTH-1:0] COUNT_ONE = 32'h0000_0001;
  localparam logic [SYNC_DEPTH-1:0] SYNC_IDLE = 2'h3;
  localparam logic [SYNC_DEPTH-1:0] SYNC_FALL = 2'h1;
endpackage : dswd_pkg

// File: design/dswd_watchdog.sv
// Dual-stage watchdog timer with carrier kick input and time-out pin
// Behaviour
// - Two sequential stages, each with its own time-out and action.
// - A no-action stage is skipped at once, with no action.
// - Reset-action expiry pulses the module reset request.
// - NMI-action expiry pulses the non-maskable interrupt.
// - Management-action expiry pulses the system management interrupt.
// - Control-action expiry pulses the OS-visible control interrupt.
// - Delay-action expiry only advances to the next stage.
// - A setting enables or disables the time-out output pin.
// - After a time-out, drive the indicator out when enabled.
`timescale 1ns/1ps
module dswd_watchdog (
  input wire logic clk, // 200 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic enable, // Watchdog run enable
  input wire dswd_pkg::dswd_stage_cfg_type stage1_cfg, // Stage one setting
  input wire dswd_pkg::dswd_stage_cfg_type stage2_cfg, // Stage two setting
  input wire logic sw_kick, // Software kick pulse
  input wire logic pin_enable, // Time-out pin activity enable
  input wire logic carrier_kick_n, // Carrier strobe, active low
  output logic timeout_indicator_out, // Time-out indicator to carrier
  output logic timed_out, // Sticky time-out status
  output dswd_pkg::dswd_event_type events, // One-cycle action pulses
  output logic [1:0] stage // One-hot active stage
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    DSWD_IDLE = 3'b001,
    DSWD_STAGE1 = 3'b010,
    DSWD_STAGE2 = 3'b100
  } dswd_state_type;

  dswd_state_type state;
  dswd_state_type next_state;
  logic [dswd_pkg::TIMEOUT_WIDTH-1:0] count;
  logic [dswd_pkg::TIMEOUT_WIDTH-1:0] next_count;
  logic [dswd_pkg::SYNC_DEPTH-1:0] sync;
  logic kick_prev;

  // ------------------------------------------------------------
  // Kick synchroniser and edge detect
  // ------------------------------------------------------------
  // First stage flop feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      sync <= dswd_pkg::SYNC_IDLE;
      kick_prev <= 1'b1;
    end else begin
      sync <= {sync[0], carrier_kick_n};
      kick_prev <= sync[1];
    end
  end

  // Falling edge on the synchronised strobe, or a software kick
  // New level low after old level high; only the second flop is read
  wire carrier_fall = ({sync[1], kick_prev} == dswd_pkg::SYNC_FALL);
  wire kick = carrier_fall | sw_kick;

  // ------------------------------------------------------------
  // Stage decode
  // ------------------------------------------------------------
  wire in_stage1 = (state == DSWD_STAGE1);
  wire in_stage2 = (state == DSWD_STAGE2);
  wire dswd_pkg::dswd_action_type cur_action = in_stage2 ? stage2_cfg.action : stage1_cfg.action;
  wire stage_off = (cur_action == dswd_pkg::DSWD_ACT_NONE);
  wire count_done = (count <= dswd_pkg::COUNT_ONE);
  // A stage ends on time-out, or at once when it has no action
  wire stage_end = (in_stage1 | in_stage2) & (stage_off | count_done);
  // A kick or a disabled watchdog on the expiry cycle suppresses the action
  wire act_fire = enable & stage_end & ~stage_off & ~kick;
  // Action decode of the running stage
  wire act_reset = (cur_action == dswd_pkg::DSWD_ACT_RESET);
  wire act_nmi = (cur_action == dswd_pkg::DSWD_ACT_NMI);
  wire act_smi = (cur_action == dswd_pkg::DSWD_ACT_SMI);
  wire act_sci = (cur_action == dswd_pkg::DSWD_ACT_SCI);
  wire act_delay = (cur_action == dswd_pkg::DSWD_ACT_DELAY);
  wire [dswd_pkg::TIMEOUT_WIDTH-1:0] s1_load = stage1_cfg.timeout;
  wire [dswd_pkg::TIMEOUT_WIDTH-1:0] s2_load = stage2_cfg.timeout;

  // Next state and count; disable and kick override the stage walk
  always_comb begin
    next_state = state;
    next_count = count;
    if (!enable) begin
      next_state = DSWD_IDLE;
      next_count = dswd_pkg::COUNT_ZERO;
    end else if (kick) begin
      next_state = DSWD_STAGE1;
      next_count = s1_load;
    end else begin
      unique case (state)
        DSWD_IDLE: begin
          // Restart stage one after a finished sequence
          next_state = DSWD_STAGE1;
          next_count = s1_load;
        end
        DSWD_STAGE1: begin
          if (stage_end) begin
            next_state = DSWD_STAGE2;
            next_count = s2_load;
          end else begin
            next_count = count - dswd_pkg::COUNT_ONE;
          end
        end
        DSWD_STAGE2: begin
          if (stage_end) begin
            next_state = DSWD_IDLE;
            next_count = dswd_pkg::COUNT_ZERO;
          end else begin
            next_count = count - dswd_pkg::COUNT_ONE;
          end
        end
        // Codes that are not one-hot fall back to idle
        default: begin
          next_state = DSWD_IDLE;
          next_count = dswd_pkg::COUNT_ZERO;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= DSWD_IDLE;
      count <= dswd_pkg::COUNT_ZERO;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // ------------------------------------------------------------
  // Actions and indicator
  // ------------------------------------------------------------
  wire dswd_pkg::dswd_event_type next_events = '{
    module_reset: act_fire && act_reset,
    nmi: act_fire && act_nmi,
    system_management_irq: act_fire && act_smi,
    os_control_irq: act_fire && act_sci
  };
  // Delay stages add time only; they do not flag a time-out
  wire fire_real = act_fire & ~act_delay;
  wire next_timed_out = enable & ~kick & (timed_out | fire_real);

  // Output registers
  always_ff @(posedge clk) begin
    if (rst) begin
      events <= '0;
      timed_out <= 1'b0;
      timeout_indicator_out <= 1'b0;
      stage <= 2'h0;
    end else begin
      events <= next_events;
      timed_out <= next_timed_out;
      timeout_indicator_out <= next_timed_out & pin_enable;
      stage <= {next_state == DSWD_STAGE2, next_state == DSWD_STAGE1};
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Kick reload, stage sequencing and count
  AST_KICK_RELOAD: assert property (enable && carrier_fall
    |=> stage == 2'h1 && count == $past(s1_load))
    else $error("kick did not reload stage one");
  AST_KICK_QUIET: assert property (enable && kick
    |=> events == '0 && !timed_out && !timeout_indicator_out)
    else $error("kick did not suppress the action");
  AST_STAGE_SEQ: assert property (in_stage1 && stage_end && enable && !kick
    |=> stage == 2'h2 && count == $past(s2_load))
    else $error("stage two not started");
  AST_STAGE_DONE: assert property (in_stage2 && stage_end && enable && !kick
    |=> stage == 2'h0)
    else $error("stage two did not end the sequence");
  AST_RESTART: assert property (state == DSWD_IDLE && enable && !kick
    |=> stage == 2'h1 && count == $past(s1_load))
    else $error("stage one not restarted");
  AST_COUNTDOWN: assert property (in_stage1 && !stage_end && enable && !kick
    |=> count == $past(count) - dswd_pkg::COUNT_ONE)
    else $error("stage count not decrementing");
  AST_COUNTDOWN2: assert property (in_stage2 && !stage_end && enable && !kick
    |=> stage == 2'h2 && count == $past(count) - dswd_pkg::COUNT_ONE)
    else $error("stage two count not decrementing");
  AST_DISABLED: assert property (!enable
    |=> stage == 2'h0 && events == '0 && !timed_out && !timeout_indicator_out)
    else $error("disabled watchdog still active");

  // Skipped stages and action pulses
  AST_SKIP_OFF: assert property (in_stage1 && stage_off && enable && !kick
    |=> stage == 2'h2 && events == '0)
    else $error("disabled stage not skipped");
  AST_SKIP_OFF2: assert property (in_stage2 && stage_off && enable && !kick
    |=> stage == 2'h0 && events == '0)
    else $error("disabled second stage not skipped");
  AST_RESET_ACT: assert property (act_fire && act_reset
    |=> events.module_reset && timed_out)
    else $error("reset action missing");
  AST_NMI_ACT: assert property (act_fire && act_nmi
    |=> events.nmi && !events.system_management_irq)
    else $error("nmi action missing");
  AST_SMI_ACT: assert property (act_fire && act_smi
    |=> events.system_management_irq && !events.os_control_irq)
    else $error("smi action missing");
  AST_SCI_ACT: assert property (act_fire && act_sci
    |=> events.os_control_irq && !events.nmi)
    else $error("sci action missing");
  AST_DELAY_QUIET: assert property (act_fire && act_delay && !timed_out
    |=> events == '0 && !timed_out)
    else $error("delay stage acted");

  // Indicator pin and sticky status
  AST_PIN_GATE: assert property (timeout_indicator_out
    |-> $past(pin_enable) && timed_out)
    else $error("indicator driven while disabled");
  AST_PIN_SET: assert property (fire_real && pin_enable
    |=> timeout_indicator_out)
    else $error("indicator not driven");
  AST_TIMEOUT_HOLD: assert property (timed_out && enable && !kick
    |=> timed_out)
    else $error("time-out status dropped without a kick");

  // Main scenarios
  COV_STAGE2: cover property (in_stage2 && act_fire);
  COV_KICK: cover property (in_stage1 && carrier_fall);
  COV_PIN: cover property (timeout_indicator_out);
  COV_SKIP: cover property (in_stage1 && stage_off);
  COV_DELAY: cover property (act_fire && act_delay);
endmodule : dswd_watchdog

// File: sim/dswd_carrier_model.sv
// Carrier board model that strobes the low-active kick line
`timescale 1ns/1ps
module dswd_carrier_model (
  input wire logic clk, // Bench clock
  input wire logic run, // Strobing on
  input wire logic [31:0] period, // Cycles between strobes
  output logic carrier_kick_n // Strobe, active low
);
  int cnt = 0;
  initial carrier_kick_n = 1'b1;
  // Low for two cycles once in each period, released high between strobes
  always @(posedge clk) begin
    cnt <= (run && cnt < period - 1) ? cnt + 1 : 0;
    carrier_kick_n <= #1 !(run && cnt < 2);
  end
endmodule : dswd_carrier_model

// File: sim/testbench.sv
// Self-checking bench for the dual-stage watchdog
`timescale 1ns/1ps
module testbench;
  logic clk, rst, enable, sw_kick, pin_enable, carrier_kick_n, run;
  logic timeout_indicator_out, timed_out;
  logic [1:0] stage;
  dswd_pkg::dswd_stage_cfg_type stage1_cfg, stage2_cfg;
  dswd_pkg::dswd_event_type events;
  int failures = 0, total_checks = 0, period = 6;
  int st, cnt, act, m_to, m_ind;
  logic [3:0] m_ev;
  logic [2:0] q;
  logic [31:0] seed = 32'hE098;
  dswd_watchdog u_dut (.clk(clk), .rst(rst), .enable(enable), .stage1_cfg(stage1_cfg),
    .stage2_cfg(stage2_cfg), .sw_kick(sw_kick), .pin_enable(pin_enable),
    .carrier_kick_n(carrier_kick_n), .timeout_indicator_out(timeout_indicator_out),
    .timed_out(timed_out), .events(events), .stage(stage));
  dswd_carrier_model u_carrier (.clk(clk), .run(run), .period(period),
    .carrier_kick_n(carrier_kick_n));
  // -----------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Reference model stepped on each edge, compared once outputs settle
  always @(posedge clk) begin
    if (rst) begin
      st = 0; cnt = 0; m_to = 0; m_ind = 0; m_ev = 4'h0; q = 3'h7;
    end else begin
      m_ev = 4'h0;
      if (!enable) begin
        st = 0; m_to = 0;
      end else if (sw_kick || (q[2] && !q[1])) begin
        st = 1; cnt = stage1_cfg.timeout; m_to = 0;
      end else if (st == 0) begin
        st = 1; cnt = stage1_cfg.timeout;
      end else begin
        act = (st == 1) ? stage1_cfg.action : stage2_cfg.action;
        if (cnt <= 1 || act == 0) begin
          if (act >= 1 && act <= 4) m_ev[4 - act] = 1'b1;
          if (act != 0 && act != 5) m_to = 1;
          cnt = stage2_cfg.timeout;
          st = (st == 1) ? 2 : 0;
        end else cnt = cnt - 1;
      end
      m_ind = m_to & pin_enable;
      q = {q[1:0], carrier_kick_n};
    end
    #2;
    cmp({2'h0, stage}, st[3:0]);
    cmp(events, m_ev);
    cmp({2'h0, timed_out, timeout_indicator_out}, {2'h0, m_to[0], m_ind[0]});
  end
  // Random settings per test, every action code in both stages
  initial begin
    rst = 1'b1; enable = 1'b0; sw_kick = 1'b0; pin_enable = 1'b0; run = 1'b0;
    stage1_cfg = '0;
    stage2_cfg = '0;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    for (int t = 0; t < 16; t++) begin
      @(posedge clk);
      #1 seed = xs(seed);
      stage1_cfg.timeout = 32'(seed[3:0]);
      stage1_cfg.action = dswd_pkg::dswd_action_type'(t % 6);
      stage2_cfg.timeout = 32'(seed[7:4]);
      stage2_cfg.action = dswd_pkg::dswd_action_type'((t + 3) % 8);
      pin_enable = seed[12];
      run = t[0];
      enable = 1'b1;
      for (int c = 0; c < 80; c++) begin
        @(posedge clk);
        #1 seed = xs(seed);
        sw_kick = (seed[4:0] == 5'h00);
      end
      @(posedge clk);
      #1 enable = 1'b0;
      sw_kick = 1'b0;
      $display("test %0d done", t);
    end
    end_sim();
  end
endmodule : testbench
